// ===== include/smos_pkg.sv
// Constants for the speed mode and oscillator select block.
// Assumes an 8-bit peripheral register port with 20-bit addresses.
//
// What this block does
// RL1: Reset clears the speed mode register to 00H.
// RL2: Speed mode register takes whole-byte writes only; bit writes are ignored.
// RL3: Two speed bits pick 10 MHz or less, above 10, 1 MHz, or prohibited.
// RL4: Halt low-power bit stops subclock to peripherals except RTC and buzzer; here only the RTC enable stays on.
// RL5: Writing one to high-speed select stalls the CPU 140.5 clocks; the stall counter holds it for 141.
// RL6: Interrupts arriving during that stall are held pending until it ends.
// RL7: Main oscillator stabilization counting continues during the stall.
// RL8: Software sets high-speed select before leaving fast oscillator or using DMA.
// RL9: Software sets high-speed select, waits two clocks, then raises clock.
// RL10: Software lowers clock to 10 MHz before clearing high-speed select.
// RL11: Software never clears the 1 MHz low-power bit once set.
// RL12: High-speed select set under key 00H; 1 MHz bit under key 5AH.
// RL13: Before low-power subclock halt, software enables only the RTC clock.
// RL14: Main oscillator mode: resonator, external clock, or input port.
// RL15: Subsystem oscillator select bit enables the subclock crystal oscillator.
// RL16: Fast oscillator run by stop bit and 20 MHz enable bit.
// RL17: Fast oscillator starts after reset; 8 or 20 MHz option runs at 8.
// RL18: Software enables 20 MHz oscillator only with adequate supply.
// RL19: 20 MHz select bit routes the 20 MHz oscillator to the CPU clock.
// RL20: Software waits 100 us after 20 MHz enable before selecting it.
// RL21: A write clearing the 1 MHz low-power bit is ignored.
package smos_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [19:0] ADDR_SPEED_MODE = 20'hF00F3;
  localparam logic [19:0] ADDR_FAST20     = 20'hF00F6;
  localparam logic [19:0] ADDR_CLK_MODE   = 20'hF00E0;
  localparam logic [19:0] ADDR_CLK_STATUS = 20'hF00E1;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int HIGH_SPEED_POS   = 0;
  localparam int ONE_MHZ_POS      = 1;
  localparam int SUB_HALT_LP_POS  = 7;
  localparam int EXT_CLK_POS      = 7;
  localparam int MAIN_OSC_POS     = 6;
  localparam int SUB_OSC_POS      = 4;
  localparam int FAST_STOP_POS    = 0;
  localparam int FAST20_EN_POS    = 0;
  localparam int FAST20_SEL_POS   = 2;
  localparam int FAST20_SUPPLY_POS = 3;

  // ----------------------------------------
  // Writable bits and reset values
  // ----------------------------------------
  localparam logic [7:0] SPEED_MODE_MASK  = 8'h83;
  localparam logic [7:0] CLK_MODE_MASK    = 8'hD0;
  localparam logic [7:0] CLK_STATUS_MASK  = 8'h01;
  localparam logic [7:0] FAST20_MASK      = 8'h05;
  localparam logic [7:0] SPEED_MODE_RESET = 8'h00;
  localparam logic [7:0] CLK_MODE_RESET   = 8'h00;
  localparam logic [7:0] CLK_STATUS_RESET = 8'h00;
  localparam logic [7:0] FAST20_RESET     = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ----------------------------------------
  // Speed ranges: {one_mhz, high_speed}
  // ----------------------------------------
  localparam logic [1:0] RANGE_LOW     = 2'h0;
  localparam logic [1:0] RANGE_HIGH    = 2'h1;
  localparam logic [1:0] RANGE_ONE_MHZ = 2'h2;
  localparam logic [1:0] RANGE_BAD     = 2'h3;

  // ----------------------------------------
  // Option byte fast oscillator frequency
  // ----------------------------------------
  localparam logic [1:0] OPT_FREQ_1MHZ  = 2'h0;
  localparam logic [1:0] OPT_FREQ_8MHZ  = 2'h1;
  localparam logic [1:0] OPT_FREQ_20MHZ = 2'h2;
  localparam logic [1:0] OPT_SETTLE     = 2'h3;

  // ----------------------------------------
  // Stall timing, in CPU clocks
  // ----------------------------------------
  localparam int         WAIT_HALF_CLOCKS = 281;
  localparam int         WAIT_CLOCKS      = (WAIT_HALF_CLOCKS + 1) / 2;
  localparam logic [7:0] WAIT_LOAD        = 8'(WAIT_CLOCKS - 1);

  typedef enum logic [1:0] {
    SMOS_IDLE = 2'b01,
    SMOS_WAIT = 2'b10
  } smos_wait_state_t;

endpackage : smos_pkg

// ===== hw/smos_wait_counter.sv
// Stall timer for a high-speed select write.
// Assumes start is a one-cycle pulse on sys_clk.
`timescale 1ns/100ps
module smos_wait_counter
  import smos_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic start,
  output logic      busy
);

  smos_wait_state_t state_reg;
  smos_wait_state_t state_next;
  logic [7:0]       cnt_reg;
  logic [7:0]       cnt_next;

  // A fresh start reloads, so the stall always ends a full span after the last write
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (start)
    begin
      state_next = SMOS_WAIT; // RL5
      cnt_next   = WAIT_LOAD;
    end
    else
    begin
      unique case (state_reg)
        SMOS_IDLE:
        begin
          cnt_next = 8'h00;
        end
        SMOS_WAIT:
        begin
          if (cnt_reg == 8'h00)
            state_next = SMOS_IDLE;
          else
            cnt_next = cnt_reg - 8'h01;
        end
        default:
        begin
          state_next = SMOS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= SMOS_IDLE;
      cnt_reg   <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // One-hot, so the wait code's own bit is a clean flop output
  assign busy = state_reg[1];

  a_wait_length: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL5
    $rose(busy) |-> busy [*8] ##0 (cnt_reg == WAIT_LOAD - 8'h07))
    else $error("stall counter does not run down from its load value");

endmodule : smos_wait_counter

// ===== hw/smos_top.sv
// Speed mode, oscillator select and fast oscillator control registers.
// Assumes CPU register port on sys_clk; data already merged for bit writes.
`timescale 1ns/100ps
module smos_top
  import smos_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [19:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_bit_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        supply_ok_pin,
  input  wire logic [1:0]  opt_fast_freq_pin,
  input  wire logic        sub_halt,
  input  wire logic        irq_in,
  output logic             cpu_wait,
  output logic             irq_pending,
  output logic             irq_to_cpu,
  output logic             ost_count_en,
  output logic      [1:0]  speed_range,
  output logic             speed_illegal,
  output logic             sub_periph_clk_en,
  output logic             sub_rtc_clk_en,
  output logic             main_resonator_en,
  output logic             main_ext_clk_en,
  output logic             main_port_mode,
  output logic             sub_osc_en,
  output logic             fast_osc_run,
  output logic             fast_osc_8mhz,
  output logic             fast20_run,
  output logic             fclk_sel_fast20
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic       supply_s1_reg;
  logic       supply_s2_reg;
  logic [1:0] opt_s1_reg;
  logic [1:0] opt_s2_reg;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      supply_s1_reg <= 1'b0;
      supply_s2_reg <= 1'b0;
      opt_s1_reg    <= 2'h0;
      opt_s2_reg    <= 2'h0;
    end
    else
    begin
      supply_s1_reg <= supply_ok_pin;
      supply_s2_reg <= supply_s1_reg;
      opt_s1_reg    <= opt_fast_freq_pin;
      opt_s2_reg    <= opt_s1_reg;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] speed_mode_reg;
  logic [7:0] speed_mode_next;
  logic [7:0] clk_mode_reg;
  logic [7:0] clk_mode_next;
  logic [7:0] clk_status_reg;
  logic [7:0] clk_status_next;
  logic [7:0] fast20_reg;
  logic [7:0] fast20_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       wait_start;
  logic       wait_busy;
  logic       hit_speed;
  logic       hit_fast20;

  assign hit_speed  = sfr_wr && (sfr_addr == ADDR_SPEED_MODE);
  assign hit_fast20 = sfr_wr && (sfr_addr == ADDR_FAST20);

  always_comb
  begin
    speed_mode_next = speed_mode_reg;
    clk_mode_next   = clk_mode_reg;
    clk_status_next = clk_status_reg;
    fast20_next     = fast20_reg;
    wait_start      = 1'b0;
    rdata_next      = rdata_reg;
    // Bit-manipulation writes leave the speed mode register untouched
    if (hit_speed && !sfr_bit_wr) // RL2
    begin
      speed_mode_next = sfr_wdata & SPEED_MODE_MASK;
      // Once set, the 1 MHz bit holds until reset
      speed_mode_next[ONE_MHZ_POS] = sfr_wdata[ONE_MHZ_POS] | speed_mode_reg[ONE_MHZ_POS]; // RL21
      wait_start = sfr_wdata[HIGH_SPEED_POS]; // RL5
    end
    if (sfr_wr && (sfr_addr == ADDR_CLK_MODE))
      clk_mode_next = sfr_wdata & CLK_MODE_MASK;
    if (sfr_wr && (sfr_addr == ADDR_CLK_STATUS))
      clk_status_next = sfr_wdata & CLK_STATUS_MASK;
    if (hit_fast20)
      fast20_next = sfr_wdata & FAST20_MASK;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        ADDR_SPEED_MODE: rdata_next = speed_mode_reg;
        ADDR_CLK_MODE:   rdata_next = clk_mode_reg;
        ADDR_CLK_STATUS: rdata_next = clk_status_reg;
        ADDR_FAST20:
        begin
          rdata_next = fast20_reg;
          rdata_next[FAST20_SUPPLY_POS] = supply_s2_reg;
        end
        default:         rdata_next = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      speed_mode_reg <= SPEED_MODE_RESET; // RL1
      clk_mode_reg   <= CLK_MODE_RESET;
      clk_status_reg <= CLK_STATUS_RESET;
      fast20_reg     <= FAST20_RESET;
      rdata_reg      <= READ_UNMAPPED;
    end
    else
    begin
      speed_mode_reg <= speed_mode_next;
      clk_mode_reg   <= clk_mode_next;
      clk_status_reg <= clk_status_next;
      fast20_reg     <= fast20_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

  // ----------------------------------------
  // High-speed select stall
  // ----------------------------------------
  smos_wait_counter u_wait (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .start   (wait_start),
    .busy    (wait_busy)
  );

  // ----------------------------------------
  // Option byte capture
  // ----------------------------------------
  // Strap sampled once the synchroniser has settled after reset release
  logic [1:0] opt_cnt_reg;
  logic [1:0] opt_cnt_next;
  logic [1:0] opt_freq_reg;
  logic [1:0] opt_freq_next;

  always_comb
  begin
    opt_cnt_next  = opt_cnt_reg;
    opt_freq_next = opt_freq_reg;
    if (opt_cnt_reg != OPT_SETTLE)
    begin
      opt_cnt_next = opt_cnt_reg + 2'h1;
      if (opt_cnt_reg == OPT_SETTLE - 2'h1)
        opt_freq_next = opt_s2_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opt_cnt_reg  <= 2'h0;
      opt_freq_reg <= OPT_FREQ_8MHZ;
    end
    else
    begin
      opt_cnt_reg  <= opt_cnt_next;
      opt_freq_reg <= opt_freq_next;
    end
  end

  // ----------------------------------------
  // Clock control outputs
  // ----------------------------------------
  logic       irq_pend_reg;
  logic       irq_pend_next;
  logic       irq_cpu_reg;
  logic       irq_cpu_next;
  logic [15:0] ctl_reg;
  logic [15:0] ctl_next;
  logic [1:0] range_sel;
  logic       main_xtal;
  logic       main_ext;
  logic       fast_on;

  assign range_sel = {speed_mode_reg[ONE_MHZ_POS], speed_mode_reg[HIGH_SPEED_POS]};
  assign main_xtal = !clk_mode_reg[EXT_CLK_POS] && clk_mode_reg[MAIN_OSC_POS];
  assign main_ext  = clk_mode_reg[EXT_CLK_POS] && clk_mode_reg[MAIN_OSC_POS];
  assign fast_on   = !clk_status_reg[FAST_STOP_POS];

  always_comb
  begin
    // Requests during the stall are held, then released once it ends
    irq_pend_next = wait_busy && (irq_in || irq_pend_reg); // RL6
    irq_cpu_next  = !wait_busy && (irq_in || irq_pend_reg); // RL6
    ctl_next      = 16'h0000;
    ctl_next[1:0] = range_sel; // RL3
    ctl_next[2]   = (range_sel == RANGE_BAD); // RL3
    ctl_next[3]   = !(sub_halt && speed_mode_reg[SUB_HALT_LP_POS]); // RL4
    ctl_next[4]   = 1'b1; // RL4
    ctl_next[5]   = main_xtal; // RL14
    ctl_next[6]   = main_ext; // RL14
    ctl_next[7]   = !clk_mode_reg[MAIN_OSC_POS]; // RL14
    ctl_next[8]   = clk_mode_reg[SUB_OSC_POS]; // RL15
    ctl_next[9]   = fast_on; // RL16 RL17
    ctl_next[10]  = (opt_freq_reg != OPT_FREQ_1MHZ); // RL17
    // 20 MHz needs the fast oscillator running and a non-1 MHz option
    ctl_next[11]  = fast20_reg[FAST20_EN_POS] && fast_on && (opt_freq_reg != OPT_FREQ_1MHZ); // RL16
    ctl_next[12]  = fast20_reg[FAST20_SEL_POS]; // RL19
    // Stabilization count is independent of the stall
    ctl_next[13]  = main_xtal; // RL7
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_pend_reg <= 1'b0;
      irq_cpu_reg  <= 1'b0;
      ctl_reg      <= 16'h0698;
    end
    else
    begin
      irq_pend_reg <= irq_pend_next;
      irq_cpu_reg  <= irq_cpu_next;
      ctl_reg      <= ctl_next;
    end
  end

  assign cpu_wait          = wait_busy;
  assign irq_pending       = irq_pend_reg;
  assign irq_to_cpu        = irq_cpu_reg;
  assign speed_range       = ctl_reg[1:0];
  assign speed_illegal     = ctl_reg[2];
  assign sub_periph_clk_en = ctl_reg[3];
  assign sub_rtc_clk_en    = ctl_reg[4];
  assign main_resonator_en = ctl_reg[5];
  assign main_ext_clk_en   = ctl_reg[6];
  assign main_port_mode    = ctl_reg[7];
  assign sub_osc_en        = ctl_reg[8];
  assign fast_osc_run      = ctl_reg[9];
  assign fast_osc_8mhz     = ctl_reg[10];
  assign fast20_run        = ctl_reg[11];
  assign fclk_sel_fast20   = ctl_reg[12];
  assign ost_count_en      = ctl_reg[13];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_reset_clear: assert property ( // RL1
    $rose(arst_n) |-> (speed_mode_reg == SPEED_MODE_RESET))
    else $error("speed mode register not clear after reset");

  a_bit_write_ignored: assert property ( // RL2
    (hit_speed && sfr_bit_wr) |=> $stable(speed_mode_reg) && !wait_busy || $past(wait_busy))
    else $error("bit write changed the speed mode register");

  a_range_follows: assert property ( // RL3
    ##1 (speed_range == $past(range_sel)) && (speed_illegal == ($past(range_sel) == RANGE_BAD)))
    else $error("speed range output does not follow the register");

  a_sub_gate: assert property ( // RL4
    (sub_halt && speed_mode_reg[SUB_HALT_LP_POS]) |=> !sub_periph_clk_en && sub_rtc_clk_en)
    else $error("subclock not gated in low-power halt");

  a_stall_start: assert property ( // RL5
    (hit_speed && !sfr_bit_wr && sfr_wdata[HIGH_SPEED_POS]) |=> cpu_wait [*8])
    else $error("high-speed select write did not stall");

  a_stall_ends: assert property ( // RL5
    $rose(cpu_wait) |-> ##[140:141] $fell(cpu_wait) || $rose(cpu_wait))
    else $error("stall length wrong");

  a_irq_held: assert property ( // RL6
    (cpu_wait && irq_in) |=> !irq_to_cpu && irq_pending)
    else $error("interrupt reached the CPU during the stall");

  a_irq_release: assert property ( // RL6
    (irq_pending && !cpu_wait) |=> irq_to_cpu)
    else $error("held interrupt not released after the stall");

  a_ost_runs: assert property ( // RL7
    (cpu_wait && main_xtal) |=> ost_count_en)
    else $error("stabilization count stopped during the stall");

  a_one_mhz_sticky: assert property ( // RL21
    speed_mode_reg[ONE_MHZ_POS] |=> speed_mode_reg[ONE_MHZ_POS])
    else $error("1 MHz low-power bit cleared by software");

  a_main_mode: assert property ( // RL14
    ##1 ($countones({main_resonator_en, main_ext_clk_en}) <= 1) && (main_port_mode == !$past(clk_mode_reg[MAIN_OSC_POS])))
    else $error("main oscillator mode decode wrong");

  a_fast20_needs_fast: assert property ( // RL16
    fast20_run |-> $past(fast_on))
    else $error("20 MHz oscillator running with fast oscillator stopped");

  a_fclk_select: assert property ( // RL19
    ##1 (fclk_sel_fast20 == $past(fast20_reg[FAST20_SEL_POS])))
    else $error("20 MHz clock select does not follow the register");

endmodule : smos_top

// ===== tb/smos_far_side.sv
// Far-side model: supply monitor and option strap seen by the block.
// Assumes the bench sets the supply state and strap code it wants.
`timescale 1ns/100ps
module smos_far_side
  import smos_pkg::*;
(
  input  wire logic       supply_good,
  input  wire logic [1:0] strap_code,
  output logic            supply_ok_pin,
  output logic      [1:0] opt_fast_freq_pin
);
  // Supply flag only rises when the rail really is adequate
  assign supply_ok_pin     = supply_good;
  // Strap is static, so the block may capture it once
  assign opt_fast_freq_pin = strap_code;
endmodule : smos_far_side

// ===== tb/smos_top_test.sv
// Self-checking bench for the speed mode and oscillator select block.
// Assumes registers reached by single-byte strobes on sys_clk.
`timescale 1ns/100ps
module smos_top_test
  import smos_pkg::*;
;
  logic sys_clk, arst_n, sfr_wr, sfr_bit_wr, sfr_rd, sub_halt, irq_in, supply_good;
  logic [19:0] sfr_addr;
  logic [7:0] sfr_wdata, sfr_rdata;
  logic [1:0] strap_code, opt_fast_freq_pin, speed_range;
  logic supply_ok_pin, cpu_wait, irq_pending, irq_to_cpu, ost_count_en, speed_illegal;
  logic sub_periph_clk_en, sub_rtc_clk_en, main_resonator_en, main_ext_clk_en, main_port_mode;
  logic sub_osc_en, fast_osc_run, fast_osc_8mhz, fast20_run, fclk_sel_fast20;
  int err_total, n_compared;
  int cyc = 0;

  smos_far_side u_smos_far_side (.supply_good(supply_good), .strap_code(strap_code),
    .supply_ok_pin(supply_ok_pin), .opt_fast_freq_pin(opt_fast_freq_pin));
  smos_top u_smos_top (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_bit_wr(sfr_bit_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .supply_ok_pin(supply_ok_pin), .opt_fast_freq_pin(opt_fast_freq_pin), .sub_halt(sub_halt),
    .irq_in(irq_in), .cpu_wait(cpu_wait), .irq_pending(irq_pending), .irq_to_cpu(irq_to_cpu),
    .ost_count_en(ost_count_en), .speed_range(speed_range), .speed_illegal(speed_illegal),
    .sub_periph_clk_en(sub_periph_clk_en), .sub_rtc_clk_en(sub_rtc_clk_en),
    .main_resonator_en(main_resonator_en), .main_ext_clk_en(main_ext_clk_en),
    .main_port_mode(main_port_mode), .sub_osc_en(sub_osc_en), .fast_osc_run(fast_osc_run),
    .fast_osc_8mhz(fast_osc_8mhz), .fast20_run(fast20_run), .fclk_sel_fast20(fclk_sel_fast20));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt

  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic bw);
    @(negedge sys_clk);
    sfr_addr   = a;
    sfr_wdata  = d;
    sfr_bit_wr = bw;
    sfr_wr     = 1'b1;
    @(negedge sys_clk);
    sfr_wr     = 1'b0;
    sfr_bit_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge sys_clk);
    sfr_rd   = 1'b0;
    chk(sfr_rdata, exp);
  endtask : rd

  task automatic do_reset();
    arst_n = 1'b0;
    wt(3);
    arst_n = 1'b1;
  endtask : do_reset

  // Waits out a stall and returns how many cycles it held
  task automatic stall_len(output int n);
    n = 0;
    while (cpu_wait === 1'b1 && n < 300)
    begin
      n++;
      if (n == 10)
        irq_in = 1'b1;
      if (n == 11)
      begin
        irq_in = 1'b0;
        chk(8'(irq_pending), 8'h01);
        chk(8'(irq_to_cpu), 8'h00);
        chk(8'(ost_count_en), 8'h01);
      end
      @(negedge sys_clk);
    end
  endtask : stall_len

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    chk(8'(speed_range), 8'(RANGE_LOW));
    chk(8'({sub_rtc_clk_en, main_port_mode, fast_osc_run, fast_osc_8mhz}), 8'h0F);
    rd(ADDR_SPEED_MODE, 8'h00);
    rd(ADDR_CLK_MODE, 8'h00);
    rd(ADDR_CLK_STATUS, 8'h00);
    rd(ADDR_FAST20, 8'h00);
    rd(20'hF00FF, READ_UNMAPPED);
  endtask : t_reset_values

  task automatic t_bit_write();
    wr(ADDR_SPEED_MODE, 8'h01, 1'b1);
    chk(8'(cpu_wait), 8'h00);
    rd(ADDR_SPEED_MODE, 8'h00);
  endtask : t_bit_write

  task automatic t_stall();
    int n;
    wr(ADDR_CLK_MODE, 8'h40, 1'b0);
    wr(ADDR_SPEED_MODE, 8'h01, 1'b0);
    stall_len(n);
    chk(8'(n), 8'(WAIT_CLOCKS));
    wt(1);
    chk(8'(irq_to_cpu), 8'h01);
    chk(8'(irq_pending), 8'h00);
    chk(8'(speed_range), 8'(RANGE_HIGH));
  endtask : t_stall

  task automatic t_ranges();
    int n;
    wr(ADDR_SPEED_MODE, 8'h02, 1'b0);
    wt(2);
    chk(8'(cpu_wait), 8'h00);
    chk(8'(speed_range), 8'(RANGE_ONE_MHZ));
    wr(ADDR_SPEED_MODE, 8'h00, 1'b0);
    rd(ADDR_SPEED_MODE, 8'h02);
    wr(ADDR_SPEED_MODE, 8'h03, 1'b0);
    stall_len(n);
    chk(8'(n), 8'(WAIT_CLOCKS));
    chk(8'(speed_range), 8'(RANGE_BAD));
    chk(8'(speed_illegal), 8'h01);
  endtask : t_ranges

  task automatic t_sub_halt();
    sub_halt = 1'b1;
    wt(2);
    chk(8'(sub_periph_clk_en), 8'h01);
    // Peripheral enables live outside; only the RTC clock is assumed on
    wr(ADDR_SPEED_MODE, 8'h82, 1'b0);
    wt(2);
    chk(8'({sub_periph_clk_en, sub_rtc_clk_en}), 8'h01);
    sub_halt = 1'b0;
    wt(2);
    chk(8'(sub_periph_clk_en), 8'h01);
    rd(ADDR_SPEED_MODE, 8'h82);
  endtask : t_sub_halt

  task automatic t_main_osc();
    logic [7:0] v [4];
    logic [3:0] e [4];
    v = '{8'h40, 8'hC0, 8'h00, 8'h10};
    // Expected order: resonator, external, port, subclock oscillator
    e = '{4'h8, 4'h4, 4'h2, 4'h3};
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CLK_MODE, v[i], 1'b0);
      wt(2);
      chk(8'({main_resonator_en, main_ext_clk_en, main_port_mode, sub_osc_en}), 8'(e[i]));
    end
  endtask : t_main_osc

  task automatic t_fast_osc();
    supply_good = 1'b1;
    wt(4);
    wr(ADDR_FAST20, 8'h01, 1'b0);
    wt(2);
    chk(8'({fast20_run, fclk_sel_fast20}), 8'h02);
    // Oscillator settles 100 us before it may be selected
    wt(10000);
    wr(ADDR_FAST20, 8'h0D, 1'b0);
    wt(2);
    chk(8'({fast20_run, fclk_sel_fast20, fast_osc_8mhz}), 8'h07);
    rd(ADDR_FAST20, 8'h0D);
    wr(ADDR_CLK_STATUS, 8'h01, 1'b0);
    wt(2);
    chk(8'({fast_osc_run, fast20_run}), 8'h00);
    rd(ADDR_CLK_STATUS, 8'h01);
    wr(ADDR_CLK_STATUS, 8'h00, 1'b0);
    wt(2);
    chk(8'({fast_osc_run, fast20_run}), 8'h03);
  endtask : t_fast_osc

  task automatic t_strap_1mhz();
    @(negedge sys_clk);
    strap_code = OPT_FREQ_1MHZ;
    do_reset();
    wt(6);
    chk(8'({fast_osc_run, fast_osc_8mhz}), 8'h02);
    rd(ADDR_SPEED_MODE, 8'h00);
    wr(ADDR_FAST20, 8'h01, 1'b0);
    wt(2);
    chk(8'(fast20_run), 8'h00);
  endtask : t_strap_1mhz

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    err_total   = 0;
    n_compared  = 0;
    sfr_addr    = 20'h00000;
    sfr_wdata   = 8'h00;
    sfr_wr      = 1'b0;
    sfr_bit_wr  = 1'b0;
    sfr_rd      = 1'b0;
    sub_halt    = 1'b0;
    irq_in      = 1'b0;
    supply_good = 1'b0;
    strap_code  = OPT_FREQ_8MHZ;
    do_reset();
    wt(5);
    t_reset_values();
    t_bit_write();
    t_stall();
    t_ranges();
    t_sub_halt();
    t_main_osc();
    t_fast_osc();
    t_strap_1mhz();
    print_verdict();
  end
endmodule : smos_top_test
